// ---- include/drp_pkg.sv ----
/*
  Constants shared by the reference-select and power-down register bank.
  Assumes a serial command decoder outside the bank that presents whole
  16-bit register accesses in the core_clk domain.
*/
package drp_pkg;
  // Register addresses as seen by the serial command decoder.
  localparam logic [4:0] ADDR_REF_WORKING = 5'h08;
  localparam logic [4:0] ADDR_SLEEP_WORKING = 5'h09;
  localparam logic [4:0] ADDR_REF_STORED = 5'h18;
  localparam logic [4:0] ADDR_SLEEP_STORED = 5'h19;
  localparam int REG_WIDTH = 16;
  localparam int FIELD_WIDTH = 2;
  // Reference select codes.
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_BANDGAP = 2'h1;
  localparam logic [1:0] REF_PIN_RAW = 2'h2;
  localparam logic [1:0] REF_PIN_BUF = 2'h3;
  // Power-down codes.
  localparam logic [1:0] SLEEP_NORMAL = 2'h0;
  localparam logic [1:0] SLEEP_1K = 2'h1;
  localparam logic [1:0] SLEEP_100K = 2'h2;
  localparam logic [1:0] SLEEP_OPEN = 2'h3;
  // Defaults after reset on volatile-only parts.
  localparam logic [15:0] REF_RESET = 16'h0000;
  localparam logic [15:0] SLEEP_RESET = 16'h0000;
  // Cycles taken to copy stored values into working copies after reset.
  localparam logic [1:0] LOAD_CYCLES = 2'h2;
endpackage

// ---- core/drp_channel_decode.sv ----
/*
  Per-channel decode of the reference select, power-down and gain fields
  into analog control strobes.
  Assumes its inputs come from registers in the same clock domain.
*/
module drp_channel_decode (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Field values.
  input wire logic [1:0] channel_ref_select,
  input wire logic [1:0] channel_sleep_select,
  input wire logic channel_gain_bit,
  // Analog controls.
  output logic ref_buffer_on,
  output logic ref_from_pin,
  output logic ref_from_bandgap,
  output logic ref_from_supply,
  output logic gain_double,
  output logic out_active,
  output logic load_1k,
  output logic load_100k
);
  logic [7:0] next_ctl;
  logic [7:0] ctl;

  // Decode the two fields; the gain bit is ignored on the supply reference.
  always_comb
  begin
    next_ctl[0] = (channel_ref_select == drp_pkg::REF_PIN_BUF) ||
                  (channel_ref_select == drp_pkg::REF_BANDGAP); // RULE1 RULE2
    next_ctl[1] = channel_ref_select[1]; // RULE1
    next_ctl[2] = (channel_ref_select == drp_pkg::REF_BANDGAP); // RULE2
    next_ctl[3] = (channel_ref_select == drp_pkg::REF_SUPPLY); // RULE2
    next_ctl[4] = channel_gain_bit && (channel_ref_select != drp_pkg::REF_SUPPLY); // RULE11
    next_ctl[5] = (channel_sleep_select == drp_pkg::SLEEP_NORMAL); // RULE8
    next_ctl[6] = (channel_sleep_select == drp_pkg::SLEEP_1K); // RULE8
    next_ctl[7] = (channel_sleep_select == drp_pkg::SLEEP_100K); // RULE7
  end

  // Registered so every control leaves straight from a flip-flop.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      ctl <= 8'h00;
    else
      ctl <= next_ctl;
  end

  assign ref_buffer_on = ctl[0];
  assign ref_from_pin = ctl[1];
  assign ref_from_bandgap = ctl[2];
  assign ref_from_supply = ctl[3];
  assign gain_double = ctl[4];
  assign out_active = ctl[5];
  assign load_1k = ctl[6];
  assign load_100k = ctl[7];
endmodule

// ---- core/drp_regs.sv ----
/*
  Reference-select and power-down register bank of a multi-channel DAC,
  with working and stored copies, plus the per-channel analog controls.
  Assumes a serial command decoder presents one-cycle read and write
  strobes with a 5-bit address and 16-bit data in the core_clk domain.
*/
// Overview of operation
// RULE1: Reference code 11 uses the reference pin with the buffer on, code 10 the pin raw.
// RULE2: Reference code 01 uses the band gap with the buffer on, code 00 the supply unbuffered.
// RULE3: While the band gap is chosen, its voltage stays on the reference pin in any sleep mode.
// RULE4: The band gap is switched off when no channel selects code 01 any longer.
// RULE5: The host reselects code 01 after wake-up if it wants the band gap again.
// RULE6: Channel n owns bits 2n+1 and 2n of the power-down register.
// RULE7: Sleep code 11 leaves the output open, code 10 loads it with 100 kilohm.
// RULE8: Sleep code 01 loads the output with 1 kilohm, code 00 is normal operation.
// RULE9: On four-channel parts bits 15 to 8 of both registers read as zero.
// RULE10: Reference select sits at 08h and 18h, power-down at 09h and 19h.
// RULE11: On the supply reference the gain bit is ignored and gain is forced to one.
// RULE12: Reset loads working copies from stored copies, or defaults on volatile parts.
module drp_regs #(
  parameter int CHANNELS = 8,
  parameter bit HAS_STORED = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Register access from the serial command decoder.
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_busy,
  // Gain bits from the neighbouring gain register.
  input wire logic [CHANNELS-1:0] channel_gain_bit,
  // Analog controls.
  output logic bandgap_on,
  output logic [CHANNELS-1:0] ref_buffer_on,
  output logic [CHANNELS-1:0] ref_from_pin,
  output logic [CHANNELS-1:0] ref_from_bandgap,
  output logic [CHANNELS-1:0] ref_from_supply,
  output logic [CHANNELS-1:0] gain_double,
  output logic [CHANNELS-1:0] out_active,
  output logic [CHANNELS-1:0] load_1k,
  output logic [CHANNELS-1:0] load_100k
);
  localparam int USED = 2 * CHANNELS;
  localparam logic [15:0] IMPL_MASK = 16'(({16{1'b1}}) >> (16 - USED)); // RULE9

  logic [15:0] ref_working;
  logic [15:0] sleep_working;
  logic [15:0] ref_stored;
  logic [15:0] sleep_stored;
  logic [15:0] next_ref_working;
  logic [15:0] next_sleep_working;
  logic [15:0] next_ref_stored;
  logic [15:0] next_sleep_stored;
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic next_bandgap;
  logic [1:0] load_cnt;
  logic [1:0] next_load_cnt;
  logic loading;

  // Maps an address to the value it reads; unimplemented bits are zero.
  function automatic logic [15:0] read_mux(input logic [4:0] a, input logic [15:0] rw,
                                           input logic [15:0] sw, input logic [15:0] rs,
                                           input logic [15:0] ss);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      drp_pkg::ADDR_REF_WORKING: v = rw; // RULE10
      drp_pkg::ADDR_SLEEP_WORKING: v = sw; // RULE10
      drp_pkg::ADDR_REF_STORED: v = HAS_STORED ? rs : 16'h0000;
      drp_pkg::ADDR_SLEEP_STORED: v = HAS_STORED ? ss : 16'h0000;
      default: v = 16'h0000;
    endcase
    return v & IMPL_MASK; // RULE9
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset load sequence: working copies are filled while loading is high.
  assign loading = (load_cnt != 2'h0);

  always_comb
  begin
    next_load_cnt = loading ? load_cnt - 2'h1 : 2'h0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      load_cnt <= drp_pkg::LOAD_CYCLES;
    else
      load_cnt <= next_load_cnt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register updates. Writes during the load window are dropped, since the
  // stored copy is still being brought across and would overwrite them.
  always_comb
  begin
    next_ref_working = ref_working;
    next_sleep_working = sleep_working;
    next_ref_stored = ref_stored;
    next_sleep_stored = sleep_stored;
    if (loading)
    begin
      next_ref_working = HAS_STORED ? ref_stored : drp_pkg::REF_RESET; // RULE12
      next_sleep_working = HAS_STORED ? sleep_stored : drp_pkg::SLEEP_RESET; // RULE12
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        drp_pkg::ADDR_REF_WORKING: next_ref_working = reg_wdata & IMPL_MASK; // RULE10
        drp_pkg::ADDR_SLEEP_WORKING: next_sleep_working = reg_wdata & IMPL_MASK; // RULE6
        drp_pkg::ADDR_REF_STORED:
          if (HAS_STORED)
            next_ref_stored = reg_wdata & IMPL_MASK; // RULE10
        drp_pkg::ADDR_SLEEP_STORED:
          if (HAS_STORED)
            next_sleep_stored = reg_wdata & IMPL_MASK;
        default: next_ref_working = ref_working;
      endcase
    end
    next_rdata = reg_read ? read_mux(reg_addr, ref_working, sleep_working, ref_stored,
                                     sleep_stored) : reg_rdata;
    next_rvalid = reg_read && !loading;
  end

  // The stored copies model nonvolatile cells and so keep their value over
  // reset; the working copies, reg_rdata and reg_rvalid are cleared and reg_busy is set.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ref_working <= drp_pkg::REF_RESET;
      sleep_working <= drp_pkg::SLEEP_RESET;
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_busy <= 1'b1;
    end
    else
    begin
      ref_working <= next_ref_working;
      sleep_working <= next_sleep_working;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
      reg_busy <= (next_load_cnt != 2'h0);
    end
  end

  always_ff @(posedge core_clk)
  begin
    ref_stored <= next_ref_stored;
    sleep_stored <= next_sleep_stored;
  end

  ////////////////////////////////////////////////////////////////////////
  // Band gap runs while any channel selects it, regardless of sleep state.
  always_comb
  begin
    next_bandgap = 1'b0;
    for (int n = 0; n < CHANNELS; n++)
      if (next_ref_working[2*n +: 2] == drp_pkg::REF_BANDGAP)
        next_bandgap = 1'b1; // RULE3 RULE4
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      bandgap_on <= 1'b0;
    else
      bandgap_on <= next_bandgap;
  end

  ////////////////////////////////////////////////////////////////////////
  // One decoder per channel turns fields into analog controls.
  for (genvar n = 0; n < CHANNELS; n++)
  begin : g_chan
    drp_channel_decode u_dec (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .channel_ref_select(ref_working[2*n +: 2]), // RULE6
      .channel_sleep_select(sleep_working[2*n +: 2]), // RULE6
      .channel_gain_bit(channel_gain_bit[n]),
      .ref_buffer_on(ref_buffer_on[n]),
      .ref_from_pin(ref_from_pin[n]),
      .ref_from_bandgap(ref_from_bandgap[n]),
      .ref_from_supply(ref_from_supply[n]),
      .gain_double(gain_double[n]),
      .out_active(out_active[n]),
      .load_1k(load_1k[n]),
      .load_100k(load_100k[n])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks next to the logic they guard.
  a_bandgap_follows_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ref_working[1:0] == drp_pkg::REF_BANDGAP) |-> bandgap_on) // RULE3
    else $error("band gap off while channel 0 selects it");
  a_bandgap_off_none: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ref_working == 16'h0000) |-> !bandgap_on) // RULE4
    else $error("band gap on while every channel uses the supply");
  a_ref_write_land: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_write && !loading && reg_addr == drp_pkg::ADDR_REF_WORKING)
      |=> ref_working == ($past(reg_wdata) & IMPL_MASK)) // RULE10
    else $error("reference write did not land");
  a_sleep_write_land: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_write && !loading && reg_addr == drp_pkg::ADDR_SLEEP_WORKING)
      |=> sleep_working == ($past(reg_wdata) & IMPL_MASK)) // RULE6
    else $error("power-down write did not land");
  a_upper_read_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_rvalid |-> (reg_rdata & ~IMPL_MASK) == 16'h0000) // RULE9
    else $error("unimplemented bits read nonzero");
  a_supply_gain_one: assert property (@(posedge core_clk) disable iff (!rst_b)
    ref_from_supply[0] |-> !gain_double[0]) // RULE11
    else $error("gain doubled on supply reference");
  a_sleep_open_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sleep_working[1:0] == drp_pkg::SLEEP_OPEN) |=>
      !out_active[0] && !load_1k[0] && !load_100k[0]) // RULE7
    else $error("open-circuit sleep not honoured");
  a_sleep_1k_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sleep_working[1:0] == drp_pkg::SLEEP_1K) |=> load_1k[0] && !out_active[0]) // RULE8
    else $error("1k sleep not honoured");
  a_pin_buffered: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ref_working[1:0] == drp_pkg::REF_PIN_BUF) |=> ref_buffer_on[0] && ref_from_pin[0]) // RULE1
    else $error("buffered pin reference not decoded");
  a_bandgap_buffer: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ref_working[1:0] == drp_pkg::REF_BANDGAP) |=> ref_buffer_on[0] && ref_from_bandgap[0]) // RULE2
    else $error("band gap reference not decoded");
  a_load_after_reset: assert property (@(posedge core_clk)
    $rose(rst_b) |-> ##2 (ref_working === (HAS_STORED ? ref_stored : drp_pkg::REF_RESET))) // RULE12
    else $error("working copy not loaded after reset");
endmodule

// ---- sim/drp_host_model.sv ----
/*
  Host model that issues whole-word register accesses to the bank.
  Assumes the bank samples one-cycle strobes on the rising core_clk edge.
*/
module drp_host_model (
  // Clock.
  input wire logic core_clk,
  // Answers from the bank.
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // Requests to the bank.
  output logic reg_write,
  output logic reg_read,
  output logic [4:0] reg_addr,
  output logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle strobes from time zero.
  initial
  begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 5'h1f;
    reg_wdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // One write pulse; released buses flip so stale data never looks valid.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One read pulse; the answer is taken at the edge that sees rvalid.
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
  // Sleep codes go in before the reference leaves the band gap, for least current.
  task automatic park(input logic [15:0] s, input logic [15:0] r);
    wr(drp_pkg::ADDR_SLEEP_WORKING, s);
    wr(drp_pkg::ADDR_REF_WORKING, r);
  endtask
  // After wake-up the band gap only returns through an explicit write.
  task automatic wake(input logic [15:0] r);
    wr(drp_pkg::ADDR_SLEEP_WORKING, 16'h0000);
    wr(drp_pkg::ADDR_REF_WORKING, r);
  endtask
endmodule

// ---- sim/dac_ref_and_powerdown_regs_tb.sv ----
/*
  Self-checking bench for the reference and power-down register bank.
  Assumes a four-channel part with stored copies, driven by the host model.
*/
module dac_ref_and_powerdown_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 4;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_write, reg_read, reg_rvalid, reg_busy, bandgap_on, ok;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, rw, sw;
  logic [CH-1:0] gain = '0;
  logic [CH-1:0] buf_on, pin, bgp, sup, gd, act, l1k, l100k;
  logic [32:0] ctl;
  logic [31:0] lfsr = 32'h249d_1c27;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  // All analog controls gathered for one comparison.
  assign ctl = {bandgap_on, buf_on, pin, bgp, sup, gd, act, l1k, l100k};
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  drp_host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  drp_regs #(.CHANNELS(CH), .HAS_STORED(1'b1)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_busy(reg_busy),
    .channel_gain_bit(gain), .bandgap_on(bandgap_on), .ref_buffer_on(buf_on),
    .ref_from_pin(pin), .ref_from_bandgap(bgp), .ref_from_supply(sup), .gain_double(gd),
    .out_active(act), .load_1k(l1k), .load_100k(l100k));
  ////////////////////////////////////////////////////////////
  // Galois shift register; repeatable because the seed is fixed.
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  // Expected controls, in the same order as ctl.
  function automatic logic [32:0] expect_ctl(input logic [15:0] r, input logic [15:0] s,
      input logic [CH-1:0] g);
    logic [7:0][CH-1:0] e;
    logic any_bg;
    any_bg = 1'b0;
    for (int n = 0; n < CH; n++)
    begin
      e[7][n] = r[2*n+:2] == 2'h3 || r[2*n+:2] == 2'h1;
      e[6][n] = r[2*n+1];
      e[5][n] = r[2*n+:2] == 2'h1;
      e[4][n] = r[2*n+:2] == 2'h0;
      e[3][n] = g[n] && r[2*n+:2] != 2'h0;
      e[2][n] = s[2*n+:2] == 2'h0;
      e[1][n] = s[2*n+:2] == 2'h1;
      e[0][n] = s[2*n+:2] == 2'h2;
      any_bg = any_bg | e[5][n];
    end
    return {any_bg, e};
  endfunction
  // Count every comparison and report each mismatch at once.
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A read must answer with rvalid and the expected word.
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    host.rd(a, d, ok);
    check({16'h0000, ok, d}, {16'h0000, 1'b1, e});
  endtask
  // Controls settle one edge after the last write is taken; checked after two.
  task automatic settle(input logic [15:0] r, input logic [15:0] s);
    repeat (2) @(posedge core_clk);
    #1;
    check(ctl, expect_ctl(r, s, gain));
  endtask
  // Reset for three cycles, then wait out the load with a bounded count.
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 20 && reg_busy !== 1'b0; i++) @(posedge core_clk);
    check({32'h0000_0000, reg_busy}, 33'h0);
  endtask
  task automatic summarize();
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Cuts a hang short well beyond the six hundred or so cycles the run needs.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end
  // Main sequence: stored copies and reload, unmapped access, random codes, park and wake.
  initial
  begin
    do_reset();
    rw = 16'ha5e4;
    sw = 16'h93c6;
    host.wr(drp_pkg::ADDR_REF_STORED, rw);
    host.wr(drp_pkg::ADDR_SLEEP_STORED, sw);
    rchk(drp_pkg::ADDR_REF_STORED, rw & 16'h00ff);
    do_reset();
    rchk(drp_pkg::ADDR_REF_WORKING, rw & 16'h00ff);
    rchk(drp_pkg::ADDR_SLEEP_WORKING, sw & 16'h00ff);
    settle(rw, sw);
    host.wr(5'h0a, 16'hffff);
    rchk(5'h0a, 16'h0000);
    for (int i = 0; i < 60; i++)
    begin
      lfsr = next_rand(lfsr);
      rw = i < 4 ? {8{2'(i)}} : lfsr[15:0];
      sw = i < 4 ? {8{2'(3 - i)}} : lfsr[31:16];
      gain <= lfsr[CH+3:4];
      host.wr(drp_pkg::ADDR_REF_WORKING, rw);
      host.wr(drp_pkg::ADDR_SLEEP_WORKING, sw);
      settle(rw, sw);
      rchk(drp_pkg::ADDR_REF_WORKING, rw & 16'h00ff);
    end
    host.park(16'h00ff, 16'h0000);
    settle(16'h0000, 16'h00ff);
    host.wake(16'h0055);
    settle(16'h0055, 16'h0000);
    summarize();
  end
endmodule
